// ---- sml_defines.vh ----
// constants of the serial motor loop command slave
`ifndef SML_DEFINES_VH
`define SML_DEFINES_VH
`define SML_CLK_NS 100
`define SML_LOOP_PERIOD_NS 10000000
`define SML_LOOP_CYCLES (`SML_LOOP_PERIOD_NS / `SML_CLK_NS)
`define SML_BAUD_DIV_RST 16'h0057
`define SML_LEAD_BYTE 8'hAA
`define SML_OLD_LEAD_BYTE 8'h80
`define SML_TARGET_CMD 3'h6
`define SML_TGT_LO_MASK 5'h1F
`define SML_TGT_HI_MASK 7'h7F
`define SML_READ_MIN 8'h81
`define SML_READ_MAX 8'hBF
`define SML_READ_LO_BASE 8'h81
`define SML_READ_TWO_BASE 8'hA1
`define SML_DUTY_FULL 16'h0258
`define SML_SPEED_OFFSET 16'h0800
`define SML_COUNT_MAX 16'hFFFF
`define SML_TARGET_RST 12'h000
`endif

// ---- sml_loop_checker.sv ----
// assertions on the ports of the motor loop command slave
module sml_loop_checker #(
   parameter LOOP_CYCLES = 20
) (
   input wire clk_sys,
   input wire rstn,
   input wire autoBaud,
   input wire speedMode,
   input wire motorDriving,
   input wire currentOver,
   input wire resetOnSat,
   input wire [11:0] scaledFeedback,
   input wire signed [15:0] propTerm,
   input wire signed [15:0] derivTerm,
   input wire [14:0] integralLimit,
   input wire [9:0] maxDuty,
   input wire txPin,
   input wire [11:0] targetValue,
   input wire signed [15:0] integral,
   input wire signed [15:0] dutyTarget,
   input wire signed [15:0] dutyApplied,
   input wire [15:0] periodCount,
   input wire fullForward,
   input wire fullReverse,
   input wire brakeCmd,
   input wire baudKnown
);
   wire signed [15:0] lim = $signed({1'b0, integralLimit});
   wire [15:0] propAbs = propTerm[15] ? -propTerm : propTerm;
   wire satNow = resetOnSat && (propAbs > {6'h00, maxDuty});
   wire accumOn = motorDriving && !resetOnSat;
   reg signed [17:0] accSum;
   // sum built from the same inputs the design saw at the update edge
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         accSum <= 18'sh0;
      end else begin
         accSum <= integral + $signed({1'b0, scaledFeedback})
            - $signed({1'b0, targetValue});
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   sequence loopTick;
      $changed(periodCount);
   endsequence
   chk_tx_quiet: assert property (autoBaud && !baudKnown |-> txPin)
      else $error("transmit line left idle level before lock");
   chk_count_step: assert property (loopTick |->
      periodCount == $past(periodCount) + 16'h1)
      else $error("period count did not step by one");
   chk_tick_gap: assert property (loopTick |=>
      (!$changed(periodCount))[*8])
      else $error("loop periods too close");
   chk_speed_target: assert property (loopTick ##0 $past(speedMode) |->
      dutyTarget == $signed({4'h0, $past(targetValue)}) - 16'sh0800)
      else $error("speed mode duty target wrong");
   chk_sum_terms: assert property (loopTick ##0 !$past(speedMode)
      && $past(integral) == 16'sh0 && integral == 16'sh0 |->
      dutyTarget == $past(propTerm) + $past(derivTerm))
      else $error("duty target is not the term sum");
   chk_idle_clear: assert property (loopTick ##0 !$past(motorDriving) |->
      integral == 16'sh0)
      else $error("integral kept while motor idle");
   chk_sat_clear: assert property (loopTick ##0 $past(satNow) |->
      integral == 16'sh0)
      else $error("integral kept on saturation");
   chk_integral_add: assert property (loopTick ##0 $past(accumOn)
      && accSum <= $past(lim) && accSum >= -$past(lim) |->
      integral == accSum)
      else $error("integral did not add the error");
   chk_integral_limit: assert property (loopTick |->
      integral <= $past(lim) && integral >= -$past(lim))
      else $error("integral beyond its limit");
   chk_drive_levels: assert property (
      fullForward == ($past(dutyTarget) >= 16'sh0258)
      && fullReverse == ($past(dutyTarget) <= -16'sh0258)
      && brakeCmd == ($past(dutyTarget) == 16'sh0))
      else $error("drive level flags disagree with duty target");
   chk_duty_range: assert property (
      dutyApplied <= 16'sh0258 && dutyApplied >= -16'sh0258)
      else $error("applied duty out of range");
   chk_current_stop: assert property (loopTick ##0 $past(currentOver) |->
      dutyApplied == 16'sh0)
      else $error("applied duty kept under overcurrent");
endmodule // sml_loop_checker
bind sml_loop_slave sml_loop_checker #(.LOOP_CYCLES(LOOP_CYCLES))
   sml_loop_checker_i (.clk_sys(clk_sys), .rstn(rstn), .autoBaud(autoBaud),
   .speedMode(speedMode), .motorDriving(motorDriving),
   .currentOver(currentOver), .resetOnSat(resetOnSat),
   .scaledFeedback(scaledFeedback), .propTerm(propTerm),
   .derivTerm(derivTerm), .integralLimit(integralLimit), .maxDuty(maxDuty),
   .txPin(txPin), .targetValue(targetValue), .integral(integral),
   .dutyTarget(dutyTarget), .dutyApplied(dutyApplied),
   .periodCount(periodCount), .fullForward(fullForward),
   .fullReverse(fullReverse), .brakeCmd(brakeCmd), .baudKnown(baudKnown));

// ---- sml_loop_slave.v ----
// command slave and loop variables of a closed loop motor controller
`include "sml_defines.vh"
module sml_loop_slave #(
   parameter LOOP_CYCLES = `SML_LOOP_CYCLES
) (
   input wire clk_sys,
   input wire rstn,
   input wire rxPin,
   input wire autoBaud,
   input wire [15:0] fixedBaudDiv,
   input wire [6:0] devNumber,
   input wire speedMode,
   input wire motorDriving,
   input wire currentOver,
   input wire resetOnSat,
   input wire [11:0] scaledFeedback,
   input wire [11:0] rawFeedback,
   input wire [7:0] currentReading,
   input wire signed [15:0] propTerm,
   input wire signed [15:0] derivTerm,
   input wire [14:0] integralLimit,
   input wire [9:0] maxDuty,
   input wire [9:0] maxAccel,
   input wire [7:0] brakeDuration,
   output wire txPin,
   output reg [11:0] targetValue,
   output reg signed [15:0] integral,
   output reg signed [15:0] dutyTarget,
   output reg signed [15:0] dutyApplied,
   output reg [15:0] periodCount,
   output reg fullForward,
   output reg fullReverse,
   output reg brakeCmd,
   output reg protocolError,
   output reg baudKnown
);
   localparam P_IDLE = 5'h01;
   localparam P_ADDR = 5'h02;
   localparam P_CMD = 5'h04;
   localparam P_DATA = 5'h08;
   localparam P_SKIP = 5'h10;
   wire [7:0] rxData;
   wire rxValid;
   wire txBusy;
   wire baudLocked;
   reg txStart;
   reg [7:0] txData;
   reg [4:0] pState;
   reg [4:0] targetLow;
   reg [15:0] rspBuf;
   reg [1:0] rspCount;
   reg [23:0] tickCnt;
   reg tick;
   reg [7:0] brakeCnt;
   reg [15:0] varVal;

   sml_uart uart (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .rxPin(rxPin),
      .autoBaud(autoBaud),
      .fixedDiv(fixedBaudDiv),
      .txData(txData),
      .txStart(txStart),
      .rxData(rxData),
      .rxValid(rxValid),
      .frameErr(),
      .txPin(txPin),
      .txBusy(txBusy),
      .baudLocked(baudLocked)
   );

   // compact bytes already carry the top bit, addressed ones get it back
   wire [7:0] cmdByte = {1'b1, rxData[6:0]};
   wire isTarget = (cmdByte[7:5] == `SML_TARGET_CMD);
   wire isRead = (cmdByte >= `SML_READ_MIN) && (cmdByte <= `SML_READ_MAX);
   wire twoByte = (cmdByte >= `SML_READ_TWO_BASE);
   wire [7:0] varOff = twoByte ? cmdByte - `SML_READ_TWO_BASE :
      cmdByte - `SML_READ_LO_BASE;
   wire hiSel = varOff[0] & ~twoByte;

   always @* begin
      case (varOff[4:1])
         4'h0: varVal = {4'h0, targetValue};
         4'h1: varVal = {4'h0, targetValue};
         4'h2: varVal = {4'h0, rawFeedback};
         4'h3: varVal = {4'h0, scaledFeedback};
         4'h4: varVal = integral;
         4'h5: varVal = dutyTarget;
         4'h6: varVal = dutyApplied;
         4'h7: varVal = {8'h00, currentReading};
         4'h8: varVal = periodCount;
         default: varVal = 16'h0000;
      endcase
   end

   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pState <= P_IDLE;
         targetLow <= 5'h00;
         targetValue <= `SML_TARGET_RST;
         rspBuf <= 16'h0000;
         rspCount <= 2'h0;
         txStart <= 1'b0;
         txData <= 8'h00;
         protocolError <= 1'b0;
         baudKnown <= 1'b0;
      end else begin
         txStart <= 1'b0;
         protocolError <= 1'b0;
         baudKnown <= baudLocked;
         // only answers queued by an accepted request ever reach the line
         if (rspCount != 2'h0 && !txBusy && !txStart) begin
            txData <= rspBuf[7:0];
            rspBuf <= {8'h00, rspBuf[15:8]};
            rspCount <= rspCount - 2'h1;
            txStart <= 1'b1;
         end else if (rxValid && (rxData[7] || pState == P_CMD)) begin
            if (rxData[7] && (pState == P_ADDR || pState == P_CMD ||
               pState == P_DATA)) begin
               protocolError <= 1'b1;
            end
            if (rxData[7] && rxData == `SML_LEAD_BYTE) begin
               pState <= P_ADDR;
            end else if (rxData == `SML_OLD_LEAD_BYTE && baudLocked) begin
               pState <= P_SKIP;
            end else if (isTarget) begin
               targetLow <= cmdByte[4:0] & `SML_TGT_LO_MASK;
               pState <= P_DATA;
            end else if (isRead) begin
               rspBuf <= hiSel ? {8'h00, varVal[15:8]} : varVal;
               rspCount <= twoByte ? 2'h2 : 2'h1;
               pState <= P_IDLE;
            end else begin
               protocolError <= 1'b1;
               pState <= P_IDLE;
            end
         end else if (rxValid) begin
            case (pState)
               P_ADDR: begin
                  pState <= (rxData[6:0] == devNumber) ? P_CMD : P_SKIP;
               end
               P_DATA: begin
                  targetValue <= {rxData[6:0] & `SML_TGT_HI_MASK, targetLow};
                  pState <= P_IDLE;
               end
               P_SKIP: begin
                  pState <= P_SKIP;
               end
               default: begin
                  protocolError <= 1'b1;
                  pState <= P_IDLE;
               end
            endcase
         end
      end
   end

   // loop arithmetic
   wire signed [12:0] loopErr = $signed({1'b0, scaledFeedback}) -
      $signed({1'b0, targetValue});
   wire signed [16:0] intSum = integral + loopErr;
   wire signed [16:0] intLim = $signed({2'b00, integralLimit});
   wire [16:0] propAbs = propTerm[15] ? 17'h00000 - {propTerm[15], propTerm} :
      {1'b0, propTerm};
   wire signed [17:0] pidSum = propTerm + integral + derivTerm;
   wire signed [15:0] pidSat = (pidSum > 18'sh07FFF) ? 16'sh7FFF :
      (pidSum < -18'sh08000) ? 16'sh8000 : pidSum[15:0];
   wire signed [15:0] speedTarget = {4'h0, targetValue} - `SML_SPEED_OFFSET;
   wire [15:0] dutyFull = `SML_DUTY_FULL;
   wire [9:0] dutyLim = (maxDuty > dutyFull[9:0]) ? dutyFull[9:0] : maxDuty;
   wire signed [15:0] limPos = {6'h00, dutyLim};
   wire signed [15:0] desired = (dutyTarget > limPos) ? limPos :
      (dutyTarget < -limPos) ? -limPos : dutyTarget;
   wire [15:0] desAbs = desired[15] ? 16'h0000 - desired : desired;
   wire [15:0] dutyAbs = dutyApplied[15] ? 16'h0000 - dutyApplied : dutyApplied;
   wire reversing = (dutyApplied != 16'h0000) &&
      (desired == 16'h0000 || desired[15] != dutyApplied[15]);
   wire stepOk = (maxAccel == 10'h000) ||
      (desAbs - dutyAbs <= {6'h00, maxAccel});
   wire signed [15:0] stepped = desired[15] ?
      dutyApplied - {6'h00, maxAccel} : dutyApplied + {6'h00, maxAccel};

   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         tickCnt <= 24'h000000;
         tick <= 1'b0;
         integral <= 16'h0000;
         dutyTarget <= 16'h0000;
         dutyApplied <= 16'h0000;
         periodCount <= 16'h0000;
         brakeCnt <= 8'h00;
         fullForward <= 1'b0;
         fullReverse <= 1'b0;
         brakeCmd <= 1'b1;
      end else begin
         tick <= (tickCnt == LOOP_CYCLES - 1);
         tickCnt <= (tickCnt == LOOP_CYCLES - 1) ? 24'h000000 :
            tickCnt + 24'h000001;
         fullForward <= dutyTarget >= $signed(`SML_DUTY_FULL);
         fullReverse <= dutyTarget <= -$signed(`SML_DUTY_FULL);
         brakeCmd <= (dutyTarget == 16'h0000);
         if (tick) begin
            periodCount <= (periodCount == `SML_COUNT_MAX) ? 16'h0000 :
               periodCount + 16'h0001;
            if (!motorDriving || (resetOnSat && propAbs > {7'h00, maxDuty})) begin
               integral <= 16'h0000;
            end else if (intSum > intLim) begin
               integral <= intLim[15:0];
            end else if (intSum < -intLim) begin
               integral <= -intLim[15:0];
            end else begin
               integral <= intSum[15:0];
            end
            dutyTarget <= speedMode ? speedTarget : pidSat;
            // applied duty follows the previous target, one period behind
            if (!motorDriving || currentOver) begin
               dutyApplied <= 16'h0000;
            end else if (brakeCnt != 8'h00) begin
               brakeCnt <= brakeCnt - 8'h01;
               dutyApplied <= 16'h0000;
            end else if (reversing) begin
               dutyApplied <= 16'h0000;
               brakeCnt <= brakeDuration;
            end else if (desAbs <= dutyAbs || stepOk) begin
               dutyApplied <= desired;
            end else begin
               dutyApplied <= stepped;
            end
         end
      end
   end
endmodule // sml_loop_slave

// ---- sml_master_model.sv ----
// serial chain master that sends commands and collects answers
module sml_master_model #(
   parameter int BIT_CLKS = 32
) (
   input wire clk_sys,
   output logic rxLine,
   input wire txLine
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] rxQ[$];
   logic [7:0] shiftIn;
   int i;
   initial rxLine = 1'b1;
   // the lead byte goes out directly: no older-style device on this chain
   task send_byte(input logic [7:0] v);
      logic [9:0] frame;
      int n;
      frame = {1'b1, v, 1'b0};
      for (n = 0; n < 10; n++) begin
         rxLine = frame[n];
         repeat (BIT_CLKS) @(posedge clk_sys);
         #1;
      end
   endtask
   // answers are caught by a free-running receiver so none is missed
   initial forever begin
      @(negedge txLine);
      repeat (BIT_CLKS / 2) @(posedge clk_sys);
      for (i = 0; i < 8; i++) begin
         repeat (BIT_CLKS) @(posedge clk_sys);
         shiftIn[i] = txLine;
      end
      repeat (BIT_CLKS) @(posedge clk_sys);
      if (txLine === 1'b1) rxQ.push_back(shiftIn);
   end
endmodule // sml_master_model

// ---- sml_uart.v ----
// serial receiver and transmitter with lead byte bit rate detection
`include "sml_defines.vh"
module sml_uart (
   input wire clk_sys,
   input wire rstn,
   input wire rxPin,
   input wire autoBaud,
   input wire [15:0] fixedDiv,
   input wire [7:0] txData,
   input wire txStart,
   output reg [7:0] rxData,
   output reg rxValid,
   output reg frameErr,
   output reg txPin,
   output reg txBusy,
   output reg baudLocked
);
   localparam R_IDLE = 5'h01;
   localparam R_MEAS = 5'h02;
   localparam R_SKIP = 5'h04;
   localparam R_DATA = 5'h08;
   localparam R_STOP = 5'h10;
   reg rxMeta;
   reg rxSync;
   reg rxPrev;
   reg [4:0] rxState;
   reg [19:0] rxCnt;
   reg [2:0] rxBit;
   reg [15:0] bitDiv;
   reg [9:0] txShift;
   reg [3:0] txBits;
   reg [15:0] txCnt;

   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rxMeta <= 1'b1;
         rxSync <= 1'b1;
         rxPrev <= 1'b1;
         rxState <= R_IDLE;
         rxCnt <= 20'h00000;
         rxBit <= 3'h0;
         rxData <= 8'h00;
         rxValid <= 1'b0;
         frameErr <= 1'b0;
         bitDiv <= `SML_BAUD_DIV_RST;
         baudLocked <= 1'b0;
      end else begin
         rxMeta <= rxPin;
         rxSync <= rxMeta;
         rxPrev <= rxSync;
         rxValid <= 1'b0;
         frameErr <= 1'b0;
         if (!autoBaud) begin
            bitDiv <= fixedDiv;
            baudLocked <= 1'b1;
         end
         case (rxState)
            R_IDLE: begin
               if (rxPrev && !rxSync) begin
                  if (baudLocked || !autoBaud) begin
                     // first sample lands mid way through data bit 0
                     rxCnt <= {4'h0, bitDiv} + {5'h00, bitDiv[15:1]};
                     rxBit <= 3'h0;
                     rxState <= R_DATA;
                  end else begin
                     rxCnt <= 20'h00001;
                     rxState <= R_MEAS;
                  end
               end
            end
            R_MEAS: begin
               // start bit and bit 0 of the lead byte are both low: two bits
               if (rxSync) begin
                  bitDiv <= rxCnt[16:1];
                  baudLocked <= 1'b1;
                  // seven bits and half the stop bit remain: 3.75 pulses
                  rxCnt <= {rxCnt[17:0], 2'h0} - {2'h0, rxCnt[19:2]};
                  rxState <= R_SKIP;
               end else if (rxCnt[16]) begin
                  rxState <= R_IDLE;
               end else begin
                  rxCnt <= rxCnt + 20'h00001;
               end
            end
            R_SKIP: begin
               // rest of the lead byte is taken as read, up to its stop bit
               if (rxCnt == 20'h00000) begin
                  rxData <= `SML_LEAD_BYTE;
                  rxValid <= 1'b1;
                  rxState <= R_IDLE;
               end else begin
                  rxCnt <= rxCnt - 20'h00001;
               end
            end
            R_DATA: begin
               if (rxCnt == 20'h00000) begin
                  rxData <= {rxSync, rxData[7:1]};
                  rxCnt <= {4'h0, bitDiv - 16'h0001};
                  rxBit <= rxBit + 3'h1;
                  if (rxBit == 3'h7) begin
                     rxState <= R_STOP;
                  end
               end else begin
                  rxCnt <= rxCnt - 20'h00001;
               end
            end
            R_STOP: begin
               if (rxCnt == 20'h00000) begin
                  rxValid <= rxSync;
                  frameErr <= !rxSync;
                  rxState <= R_IDLE;
               end else begin
                  rxCnt <= rxCnt - 20'h00001;
               end
            end
            default: begin
               rxState <= R_IDLE;
            end
         endcase
      end
   end

   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         txPin <= 1'b1;
         txBusy <= 1'b0;
         txShift <= 10'h3FF;
         txBits <= 4'h0;
         txCnt <= 16'h0000;
      end else if (!txBusy) begin
         txPin <= 1'b1;
         if (txStart) begin
            txShift <= {1'b1, txData, 1'b0};
            txBits <= 4'h0;
            txCnt <= 16'h0000;
            txBusy <= 1'b1;
         end
      end else if (txCnt == 16'h0000) begin
         txPin <= txShift[0];
         txShift <= {1'b1, txShift[9:1]};
         txCnt <= bitDiv - 16'h0001;
         txBits <= txBits + 4'h1;
      end else if (txCnt == 16'h0001 && txBits == 4'hA) begin
         txBusy <= 1'b0;
         txCnt <= 16'h0000;
      end else begin
         txCnt <= txCnt - 16'h0001;
      end
   end
endmodule // sml_uart

// ---- tb.sv ----
// self-checking bench of the motor loop command slave
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int BIT = 32;
   localparam logic [6:0] DEV = 7'h0D;
   logic clk_sys = 1'b0, rstn = 1'b0, autoBaud = 1'b1, speedMode = 1'b0;
   logic motorDriving = 1'b0, currentOver = 1'b0, resetOnSat = 1'b0;
   logic [15:0] fixedBaudDiv = 16'h0057;
   logic [11:0] scaledFeedback = 12'h000, rawFeedback = 12'h000;
   logic [7:0] currentReading = 8'h00, brakeDuration = 8'h00;
   logic signed [15:0] propTerm = 16'sh0, derivTerm = 16'sh0;
   logic [14:0] integralLimit = 15'h7FFF;
   logic [9:0] maxDuty = 10'h12C, maxAccel = 10'h000;
   wire rxPin, txPin, fullForward, fullReverse, brakeCmd;
   wire protocolError, baudKnown;
   wire [11:0] targetValue;
   wire signed [15:0] integral, dutyTarget, dutyApplied;
   wire [15:0] periodCount;
   int failures = 0, tests_run = 0, errPulses = 0, tgt, i0, k;
   logic [31:0] seed = 32'hF33C;
   logic [7:0] b;
   logic [7:0] cmds[7] = '{8'hA3, 8'hA1, 8'hA5, 8'h87, 8'h88, 8'h8F, 8'hBF};
   always #50 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (protocolError === 1'b1) errPulses++;
   sml_loop_slave #(.LOOP_CYCLES(20)) sml_loop_slave_i (.clk_sys(clk_sys),
      .rstn(rstn), .rxPin(rxPin), .autoBaud(autoBaud),
      .fixedBaudDiv(fixedBaudDiv), .devNumber(DEV), .speedMode(speedMode),
      .motorDriving(motorDriving), .currentOver(currentOver),
      .resetOnSat(resetOnSat), .scaledFeedback(scaledFeedback),
      .rawFeedback(rawFeedback), .currentReading(currentReading),
      .propTerm(propTerm), .derivTerm(derivTerm),
      .integralLimit(integralLimit), .maxDuty(maxDuty), .maxAccel(maxAccel),
      .brakeDuration(brakeDuration), .txPin(txPin),
      .targetValue(targetValue), .integral(integral),
      .dutyTarget(dutyTarget), .dutyApplied(dutyApplied),
      .periodCount(periodCount), .fullForward(fullForward),
      .fullReverse(fullReverse), .brakeCmd(brakeCmd),
      .protocolError(protocolError), .baudKnown(baudKnown));
   sml_master_model #(.BIT_CLKS(BIT)) sml_master_model_i (.clk_sys(clk_sys),
      .rxLine(rxPin), .txLine(txPin));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
         failures++;
      end
   endtask
   task cmd(input logic [6:0] dev, input logic [7:0] c);
      sml_master_model_i.send_byte(8'hAA);
      sml_master_model_i.send_byte({1'b0, dev});
      sml_master_model_i.send_byte({1'b0, c[6:0]});
   endtask
   task get(output logic [7:0] v);
      for (k = 0; k < 40 * BIT && sml_master_model_i.rxQ.size() == 0;
         k++) begin
         @(posedge clk_sys);
         #1;
      end
      if (sml_master_model_i.rxQ.size() == 0) begin
         failures++;
         report_and_stop;
      end else begin
         v = sml_master_model_i.rxQ.pop_front();
      end
   endtask
   // expected reading worked out from the bench's own copy of the variables
   function automatic logic [15:0] model_var(input logic [7:0] c);
      int v;
      logic [15:0] r;
      v = (c >= 8'hA1) ? (c - 8'hA1) >> 1 : (c - 8'h81) >> 1;
      case (v)
         0, 1: r = 16'(tgt);
         2: r = {4'h0, rawFeedback};
         3: r = {4'h0, scaledFeedback};
         7: r = {8'h00, currentReading};
         default: r = 16'h0000;
      endcase
      if (c < 8'hA1 && c[0] == 1'b0) r = r >> 8;
      return r;
   endfunction
   task ticks(input int n);
      logic [15:0] p;
      int j, w;
      for (j = 0; j < n; j++) begin
         p = periodCount;
         for (w = 0; w < 100 && periodCount === p; w++) begin
            @(posedge clk_sys);
            #1;
         end
         check(periodCount, p + 16'h1);
         if (periodCount === p) report_and_stop;
      end
   endtask
   initial begin
      seed = xs(seed);
      tgt = 1000 + seed[10:0];
      seed = xs(seed);
      rawFeedback = seed[11:0];
      scaledFeedback = seed[23:12];
      currentReading = seed[31:24];
      seed = xs(seed);
      propTerm = 16'($signed(seed[9:0]));
      derivTerm = 16'($signed(seed[25:16]));
      repeat (10) @(posedge clk_sys);
      #1 rstn = 1'b1;
      check(16'(txPin), 16'h1);
      check(16'(brakeCmd), 16'h1);
      check(16'(targetValue), 16'h0);
      repeat (5) @(posedge clk_sys);
      #1;
      cmd(DEV, 8'hC0 | tgt[4:0]);
      sml_master_model_i.send_byte({1'b0, 7'(tgt >> 5) & 7'h7F});
      check(16'(baudKnown), 16'h1);
      check(16'(targetValue), 16'(tgt));
      cmd(DEV + 7'h1, 8'hA3);
      sml_master_model_i.send_byte(8'h80);
      sml_master_model_i.send_byte(8'h23);
      repeat (30 * BIT) @(posedge clk_sys);
      #1;
      check(16'(sml_master_model_i.rxQ.size()), 16'h0);
      foreach (cmds[c]) begin
         cmd(DEV, cmds[c]);
         get(b);
         check({8'h00, b}, model_var(cmds[c]) & 16'h00FF);
         if (cmds[c] >= 8'hA1) begin
            get(b);
            check({8'h00, b}, model_var(cmds[c]) >> 8);
         end
      end
      check(16'(errPulses), 16'h0);
      sml_master_model_i.send_byte(8'h05);
      repeat (4) @(posedge clk_sys);
      #1;
      check(16'(errPulses), 16'h1);
      speedMode = 1'b1;
      ticks(2);
      check(dutyTarget, 16'(tgt - 2048));
      // drive level flags follow the duty target one clock later
      @(posedge clk_sys);
      #1;
      check(16'(fullForward), 16'(tgt - 2048 >= 600));
      check(16'(fullReverse), 16'(tgt - 2048 <= -600));
      speedMode = 1'b0;
      ticks(2);
      check(integral, 16'h0);
      check(dutyTarget, propTerm + derivTerm);
      motorDriving = 1'b1;
      scaledFeedback = 12'(tgt - 30);
      ticks(1);
      i0 = integral;
      ticks(1);
      check(integral, 16'(i0 - 30));
      scaledFeedback = 12'(tgt + 500);
      integralLimit = 15'h0064;
      ticks(2);
      check(integral, 16'h0064);
      scaledFeedback = 12'(tgt - 500);
      ticks(2);
      check(integral, 16'hFF9C);
      cmd(DEV, 8'hA9);
      get(b);
      check({8'h00, b}, 16'h009C);
      get(b);
      check({8'h00, b}, 16'h00FF);
      resetOnSat = 1'b1;
      propTerm = 16'sh02BC;
      ticks(1);
      check(integral, 16'h0);
      currentOver = 1'b1;
      ticks(1);
      check(dutyApplied, 16'h0);
      // target stays far above the cap, so each period adds one step
      currentOver = 1'b0;
      maxAccel = 10'h00A;
      ticks(2);
      check(dutyApplied, 16'h0014);
      // second reset, now with the fixed bit rate and a compact read
      autoBaud = 1'b0;
      fixedBaudDiv = 16'h0020;
      rstn = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1 rstn = 1'b1;
      check(16'(targetValue), 16'h0);
      check(16'(brakeCmd), 16'h1);
      repeat (3) @(posedge clk_sys);
      #1;
      check(16'(baudKnown), 16'h1);
      sml_master_model_i.send_byte(8'hA7);
      get(b);
      check({8'h00, b}, model_var(8'hA7) & 16'h00FF);
      get(b);
      check({8'h00, b}, model_var(8'hA7) >> 8);
      report_and_stop;
   end
endmodule // tb
